// [design/cta_pkg.sv]
package cta_pkg;
  // coprocessor command fields
  localparam logic [2:0] CTA_OP1_TEST = 3'h2;
  localparam logic [2:0] CTA_OP1_TDR = 3'h3;
  localparam logic [2:0] CTA_OP1_STD = 3'h0;
  localparam logic [3:0] CTA_CRN_TEST = 4'hf;
  localparam logic [3:0] CTA_CRN_VICT = 4'h9;
  localparam logic [3:0] CTA_CRM_CAM_I = 4'h5;
  localparam logic [3:0] CTA_CRM_CAM_D = 4'h6;
  localparam logic [3:0] CTA_CRM_CAM_B = 4'h7;
  localparam logic [3:0] CTA_CRM_RAM_I = 4'h9;
  localparam logic [3:0] CTA_CRM_RAM_D = 4'ha;
  localparam logic [3:0] CTA_CRM_RAM_B = 4'hb;
  localparam logic [3:0] CTA_CRM_TDR_I = 4'h1;
  localparam logic [3:0] CTA_CRM_TDR_D = 4'h2;
  localparam logic [3:0] CTA_CRM_TDR_B = 4'h3;
  localparam logic [3:0] CTA_CRM_VBASE = 4'h0;
  localparam logic [3:0] CTA_CRM_VONLY = 4'h1;
  localparam logic [2:0] CTA_OP2_RD = 3'h2;
  localparam logic [2:0] CTA_OP2_WR = 3'h6;
  localparam logic [2:0] CTA_OP2_MATCH = 3'h5;
  localparam logic [2:0] CTA_OP2_TDR = 3'h0;
  localparam logic [2:0] CTA_OP2_VD = 3'h0;
  localparam logic [2:0] CTA_OP2_VI = 3'h1;
  // operand field positions
  localparam int CTA_TAG_LSB = 8;
  localparam int CTA_TAG_W = 24;
  localparam int CTA_SEG_LSB = 5;
  localparam int CTA_SEG_W = 3;
  localparam int CTA_VLD_BIT = 4;
  localparam int CTA_DE_BIT = 3;
  localparam int CTA_DO_BIT = 2;
  localparam int CTA_WB_BIT = 1;
  localparam int CTA_WORD_LSB = 2;
  localparam int CTA_WORD_W = 3;
  localparam int CTA_IDX_LSB = 26;
  localparam int CTA_IDX_W = 6;
  localparam int CTA_NSEG = 8;
  localparam int CTA_NIDX = 64;
  localparam int CTA_NWORD = 8;
  localparam int CTA_HIT_BIT = 0;
  // cam entry: valid, tag, dirty even, dirty odd, writeback
  localparam int CTA_ENT_W = CTA_TAG_W + 4;
  localparam logic [31:0] CTA_TDR_RST = 32'h0;
  localparam logic [5:0] CTA_VICT_RST = 6'h0;
endpackage

// [design/cta_vict.sv]
`timescale 1ns/1ps
`default_nettype none
// per-segment victim pointers for one cache
module cta_vict (
  input wire logic clk,
  input wire logic srst,
  input wire logic load_all,
  input wire logic load_seg,
  input wire logic [cta_pkg::CTA_IDX_W-1:0] load_idx,
  input wire logic [cta_pkg::CTA_SEG_W-1:0] load_sel,
  input wire logic [cta_pkg::CTA_SEG_W-1:0] seg,
  input wire logic cam_acc,
  input wire logic ram_acc,
  input wire logic prod_test,
  output logic [cta_pkg::CTA_IDX_W-1:0] idx
);
  import cta_pkg::*;
  logic [CTA_IDX_W-1:0] vict_r [CTA_NSEG];
  logic [CTA_NSEG-1:0] all_mode_r;
  logic inc;

  assign idx = vict_r[seg];
  // production test: only cam reads and writes advance; ram_acc is then ignored
  assign inc = cam_acc | (ram_acc & all_mode_r[seg] & ~prod_test);

  genvar g;
  generate
    for (g = 0; g < CTA_NSEG; g++) begin : g_seg
      always_ff @(posedge clk) begin
        if (srst) begin
          vict_r[g] <= CTA_VICT_RST;
          all_mode_r[g] <= 1'b0;
        end else if (load_all) begin
          vict_r[g] <= load_idx;
          all_mode_r[g] <= 1'b1;
        end else if (load_seg && load_sel == CTA_SEG_W'(g)) begin
          vict_r[g] <= load_idx;
          all_mode_r[g] <= 1'b0;
        end else if (inc && seg == CTA_SEG_W'(g)) begin
          vict_r[g] <= vict_r[g] + 6'h1;
        end
      end
    end
  endgenerate
endmodule // cta_vict
`default_nettype wire

// [design/cta_store.sv]
`timescale 1ns/1ps
`default_nettype none
// cam and data ram of one cache, addressed by segment and index
module cta_store (
  input wire logic clk,
  input wire logic [cta_pkg::CTA_SEG_W-1:0] seg,
  input wire logic [cta_pkg::CTA_IDX_W-1:0] idx,
  input wire logic [cta_pkg::CTA_WORD_W-1:0] word,
  input wire logic cam_we,
  input wire logic [cta_pkg::CTA_ENT_W-1:0] cam_wdata,
  input wire logic ram_we,
  input wire logic [31:0] ram_wdata,
  input wire logic [cta_pkg::CTA_TAG_W-1:0] match_tag,
  output logic [cta_pkg::CTA_ENT_W-1:0] cam_rdata,
  output logic [31:0] ram_rdata,
  output logic match_hit,
  output logic [31:0] match_data
);
  import cta_pkg::*;
  logic [CTA_ENT_W-1:0] cam_m [CTA_NSEG*CTA_NIDX];
  logic [31:0] ram_m [CTA_NSEG*CTA_NIDX*CTA_NWORD];
  logic [CTA_SEG_W+CTA_IDX_W-1:0] ea;
  logic [CTA_IDX_W-1:0] hit_idx;

  assign ea = {seg, idx};
  assign cam_rdata = cam_m[ea];
  assign ram_rdata = ram_m[{ea, word}];

  // associative search inside the segment; no translation, no fill on miss
  always_comb begin
    match_hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < CTA_NIDX; i++) begin
      if (!match_hit && cam_m[{seg, CTA_IDX_W'(i)}][CTA_ENT_W-1] &&
          cam_m[{seg, CTA_IDX_W'(i)}][CTA_ENT_W-2 -: CTA_TAG_W] == match_tag) begin
        match_hit = 1'b1;
        hit_idx = CTA_IDX_W'(i);
      end
    end
  end
  assign match_data = ram_m[{seg, hit_idx, word}];

  always_ff @(posedge clk) begin
    if (cam_we) begin
      cam_m[ea] <= cam_wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_m[{ea, word}] <= ram_wdata;
    end
  end
endmodule // cta_store
`default_nettype wire

// [design/cta_top.sv]
// Operation
// - cam read c5/c6/c7 op2 2 to test data
// - cam write c5/c6/c7 op2 6 from operand
// - operand carries valid, dirty even/odd, writeback
// - ram read c9/c10/c11 op2 2 to test data
// - ram write c9/c10/c11 op2 6 from data
// - cam-match ram read op2 5, hit and data
// - test data write op1 3, c1/c2/c3; reads
// - ram commands: seg 7:5, word 4:2
// - match command: tag 31:8, seg, word
// - ram read returns full 32-bit word
// - production test mode: only cam reads and writes advance
// - entry index from segment victim pointer
// - combined load: increment after cam and ram reads and writes
// - victim-only load: increment after cam only
// - combined victim/base write c9,c0, 31:26
// - victim-only write c9,c1, seg 7:5
// - cam read snapshots victim pointer per cache
// - match skips translation, no fill on miss
// - data through test registers, operand addresses
`timescale 1ns/1ps
`default_nettype none
module cta_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_op1,
  input wire logic [3:0] cmd_crn,
  input wire logic [3:0] cmd_crm,
  input wire logic [2:0] cmd_op2,
  input wire logic [31:0] cmd_wdata,
  input wire logic prod_test,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic [31:0] icache_test_data,
  output logic [31:0] dcache_test_data,
  output logic [5:0] victim_snapshot_reg_i,
  output logic [5:0] victim_snapshot_reg_d
);
  import cta_pkg::*;

  logic [31:0] tdr_r [2];
  logic [5:0] snap_r [2];
  logic [31:0] rd_data_r;
  logic rd_valid_r;
  logic test_op, cam_rd, cam_wr, ram_rd, ram_wr, match_rd;
  logic [1:0] sel_cam, sel_ram, sel_tdr;
  logic vict_all, vict_seg, vict_icache;
  logic [CTA_SEG_W-1:0] seg;
  logic [CTA_WORD_W-1:0] word;
  logic [CTA_TAG_W-1:0] tag;
  logic [CTA_ENT_W-1:0] cam_wdata;
  logic [CTA_IDX_W-1:0] idx [2];
  logic [CTA_ENT_W-1:0] cam_rdata [2];
  logic [31:0] ram_rdata [2];
  logic [31:0] match_data [2];
  logic match_hit [2];

  // cache select: bit 0 instruction, bit 1 data; both-code sets both
  function automatic logic [1:0] csel(input logic [3:0] crm, input logic [3:0] ci,
                                      input logic [3:0] cd, input logic [3:0] cb);
    logic [1:0] s;
    s = 2'b00;
    if (crm == ci) begin
      s = 2'b01;
    end else if (crm == cd) begin
      s = 2'b10;
    end else if (crm == cb) begin
      s = 2'b11;
    end
    return s;
  endfunction

  assign test_op = cmd_valid && !cmd_read && cmd_op1 == CTA_OP1_TEST && cmd_crn == CTA_CRN_TEST;
  assign sel_cam = csel(cmd_crm, CTA_CRM_CAM_I, CTA_CRM_CAM_D, CTA_CRM_CAM_B);
  assign sel_ram = csel(cmd_crm, CTA_CRM_RAM_I, CTA_CRM_RAM_D, CTA_CRM_RAM_B);
  assign sel_tdr = csel(cmd_crm, CTA_CRM_TDR_I, CTA_CRM_TDR_D, CTA_CRM_TDR_B);
  assign cam_rd = test_op && cmd_op2 == CTA_OP2_RD && sel_cam != 2'b00;
  assign cam_wr = test_op && cmd_op2 == CTA_OP2_WR && sel_cam != 2'b00;
  assign ram_rd = test_op && cmd_op2 == CTA_OP2_RD && sel_ram != 2'b00;
  assign ram_wr = test_op && cmd_op2 == CTA_OP2_WR && sel_ram != 2'b00;
  assign match_rd = test_op && cmd_op2 == CTA_OP2_MATCH && sel_cam != 2'b00;

  assign vict_icache = cmd_op2 == CTA_OP2_VI;
  assign vict_all = cmd_valid && !cmd_read && cmd_op1 == CTA_OP1_STD &&
                    cmd_crn == CTA_CRN_VICT && cmd_crm == CTA_CRM_VBASE &&
                    (cmd_op2 == CTA_OP2_VD || vict_icache);
  assign vict_seg = cmd_valid && !cmd_read && cmd_op1 == CTA_OP1_STD &&
                    cmd_crn == CTA_CRN_VICT && cmd_crm == CTA_CRM_VONLY &&
                    (cmd_op2 == CTA_OP2_VD || vict_icache);

  // operand only addresses; ram bits outside seg/word are ignored
  assign seg = cmd_wdata[CTA_SEG_LSB +: CTA_SEG_W];
  assign word = cmd_wdata[CTA_WORD_LSB +: CTA_WORD_W];
  assign tag = cmd_wdata[CTA_TAG_LSB +: CTA_TAG_W];
  assign cam_wdata = {cmd_wdata[CTA_VLD_BIT], tag, cmd_wdata[CTA_DE_BIT],
                      cmd_wdata[CTA_DO_BIT], cmd_wdata[CTA_WB_BIT]};

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_cache
      // c = 0 instruction side, c = 1 data side; both may act together
      cta_vict u_vict (
        .clk(clk),
        .srst(srst),
        .load_all(vict_all && (vict_icache == (c == 0))),
        .load_seg(vict_seg && (vict_icache == (c == 0))),
        .load_idx(cmd_wdata[CTA_IDX_LSB +: CTA_IDX_W]),
        .load_sel(seg),
        .seg(seg),
        .cam_acc((cam_rd || cam_wr) && sel_cam[c]),
        .ram_acc((ram_rd || ram_wr) && sel_ram[c]),
        .prod_test(prod_test),
        .idx(idx[c])
      );
      cta_store u_store (
        .clk(clk),
        .seg(seg),
        .idx(idx[c]),
        .word(word),
        .cam_we(cam_wr && sel_cam[c]),
        .cam_wdata(cam_wdata),
        .ram_we(ram_wr && sel_ram[c]),
        .ram_wdata(tdr_r[c]),
        .match_tag(tag),
        .cam_rdata(cam_rdata[c]),
        .ram_rdata(ram_rdata[c]),
        .match_hit(match_hit[c]),
        .match_data(match_data[c])
      );

      always_ff @(posedge clk) begin
        if (srst) begin
          tdr_r[c] <= CTA_TDR_RST;
        end else if (cam_rd && sel_cam[c]) begin
          // tag word: tag 31:8, seg, flags as in the write layout
          tdr_r[c] <= {cam_rdata[c][CTA_ENT_W-2 -: CTA_TAG_W], seg, cam_rdata[c][CTA_ENT_W-1],
                       cam_rdata[c][2:0], 1'b0};
        end else if (ram_rd && sel_ram[c]) begin
          tdr_r[c] <= ram_rdata[c];
        end else if (match_rd && sel_cam[c]) begin
          // a miss leaves the data bits clear and only flags status
          tdr_r[c] <= match_hit[c] ? match_data[c] : 32'h0;
        end else if (cmd_valid && !cmd_read && cmd_op1 == CTA_OP1_TDR &&
                     cmd_crn == CTA_CRN_TEST && cmd_op2 == CTA_OP2_TDR && sel_tdr[c]) begin
          tdr_r[c] <= cmd_wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          snap_r[c] <= CTA_VICT_RST;
        end else if (cam_rd && sel_cam[c]) begin
          snap_r[c] <= idx[c];
        end
      end
    end
  endgenerate

  // hit status for match reads sits on its own output word
  logic [1:0] hit_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      hit_r <= 2'b00;
    end else if (match_rd) begin
      hit_r <= {match_hit[1] & sel_cam[1], match_hit[0] & sel_cam[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_r <= 32'h0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      if (cmd_valid && cmd_read && cmd_op1 == CTA_OP1_TDR && cmd_crn == CTA_CRN_TEST &&
          cmd_op2 == CTA_OP2_TDR) begin
        rd_valid_r <= 1'b1;
        if (cmd_crm == CTA_CRM_TDR_I) begin
          rd_data_r <= tdr_r[0];
        end else if (cmd_crm == CTA_CRM_TDR_D) begin
          rd_data_r <= tdr_r[1];
        end else if (cmd_crm == CTA_CRM_VBASE) begin
          // crm 0 with op1 3 reads the last match status
          rd_data_r <= {30'h0, hit_r};
        end else begin
          rd_data_r <= 32'h0;
        end
      end
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign icache_test_data = tdr_r[0];
  assign dcache_test_data = tdr_r[1];
  assign victim_snapshot_reg_i = snap_r[0];
  assign victim_snapshot_reg_d = snap_r[1];

  // assertions
  logic [5:0] idx_d_q;
  logic cam_d_q;
  always_ff @(posedge clk) begin
    idx_d_q <= idx[1];
    cam_d_q <= (cam_rd || cam_wr) && sel_cam[1];
  end

  property p_snap;
    @(posedge clk) disable iff (srst) (cam_rd && sel_cam[1]) |=> snap_r[1] == $past(idx[1]);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not loaded");
  property p_tdr_wr;
    @(posedge clk) disable iff (srst)
      (cmd_valid && !cmd_read && cmd_op1 == CTA_OP1_TDR && cmd_crn == CTA_CRN_TEST &&
       cmd_op2 == CTA_OP2_TDR && cmd_crm == CTA_CRM_TDR_B && !cam_rd && !ram_rd && !match_rd)
      |=> tdr_r[0] == $past(cmd_wdata) && tdr_r[1] == $past(cmd_wdata);
  endproperty
  a_tdr_wr: assert property (p_tdr_wr) else $error("test data write lost");
  property p_ramrd;
    @(posedge clk) disable iff (srst) (ram_rd && sel_ram[0]) |=> tdr_r[0] == $past(ram_rdata[0]);
  endproperty
  a_ramrd: assert property (p_ramrd) else $error("ram word not captured");
  property p_ramrd_d;
    @(posedge clk) disable iff (srst) (ram_rd && sel_ram[1]) |=> tdr_r[1] == $past(ram_rdata[1]);
  endproperty
  a_ramrd_d: assert property (p_ramrd_d) else $error("data side ram word not captured");
  // a cam access always moves the pointer, in test mode too
  property p_caminc;
    @(posedge clk) disable iff (srst)
      (cam_rd && sel_cam[1]) ##1 (seg == $past(seg)) |-> idx[1] == idx_d_q + 6'h1;
  endproperty
  a_caminc: assert property (p_caminc) else $error("pointer did not advance on cam read");
  property p_prod;
    @(posedge clk) disable iff (srst)
      (ram_rd && sel_ram[1] && prod_test && !vict_all && !vict_seg) ##1 (seg == $past(seg))
      |-> idx[1] == idx_d_q;
  endproperty
  a_prod: assert property (p_prod) else $error("pointer moved on ram in test mode");
  property p_rdv;
    @(posedge clk) disable iff (srst) rd_valid |-> $past(cmd_valid && cmd_read);
  endproperty
  a_rdv: assert property (p_rdv) else $error("spurious read answer");
  property p_rdd;
    @(posedge clk) disable iff (srst)
      (cmd_valid && cmd_read && cmd_op1 == CTA_OP1_TDR && cmd_crn == CTA_CRN_TEST &&
       cmd_op2 == CTA_OP2_TDR && cmd_crm == CTA_CRM_TDR_D)
      |=> rd_valid && rd_data == $past(tdr_r[1]);
  endproperty
  a_rdd: assert property (p_rdd) else $error("data side read answer wrong");
  property p_vload;
    @(posedge clk) disable iff (srst) (vict_all && !vict_icache) ##1 !cam_d_q
      |-> idx[1] == $past(cmd_wdata[31:26]);
  endproperty
  a_vload: assert property (p_vload) else $error("combined pointer load lost");
  property p_vseg;
    @(posedge clk) disable iff (srst)
      (vict_seg && !vict_icache) ##1 (seg == $past(seg))
      |-> idx[1] == $past(cmd_wdata[31:26]);
  endproperty
  a_vseg: assert property (p_vseg) else $error("segment pointer load lost");
  property p_idle_rd;
    @(posedge clk) disable iff (srst) !cmd_valid |=> !rd_valid;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read answer with no command");
  property p_noop;
    @(posedge clk) disable iff (srst)
      (!cmd_valid) |=> $stable(tdr_r[0]) && $stable(tdr_r[1]);
  endproperty
  a_noop: assert property (p_noop) else $error("test data changed with no command");
  property p_snapkeep;
    @(posedge clk) disable iff (srst) !(cam_rd && sel_cam[0]) |=> $stable(snap_r[0]);
  endproperty
  a_snapkeep: assert property (p_snapkeep) else $error("snapshot changed");
  property p_hit;
    @(posedge clk) disable iff (srst) (match_rd && sel_cam[1]) |=> hit_r[1] == $past(match_hit[1]);
  endproperty
  a_hit: assert property (p_hit) else $error("hit status wrong");
  c_camrd: cover property (@(posedge clk) cam_rd && sel_cam == 2'b11);
  c_ramwr: cover property (@(posedge clk) ram_wr);
  c_match: cover property (@(posedge clk) match_rd ##1 hit_r != 2'b00);
  c_vload: cover property (@(posedge clk) vict_all ##1 ram_rd);
endmodule // cta_top
`default_nettype wire

// [tb/cta_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// behavioural core: issues one coprocessor transfer per cycle from falling edges
module cta_core_model (
  input wire logic clk,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  output logic cmd_valid,
  output logic cmd_read,
  output logic [2:0] cmd_op1,
  output logic [3:0] cmd_crn,
  output logic [3:0] cmd_crm,
  output logic [2:0] cmd_op2,
  output logic [31:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_op1 = 3'h0;
    cmd_crn = 4'h0;
    cmd_crm = 4'h0;
    cmd_op2 = 3'h0;
    cmd_wdata = 32'h0;
  end
  // caller sits at a falling edge; back to back calls keep valid high
  task automatic xfer(input logic rd, input logic [2:0] op1, input logic [3:0] crn,
      input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd,
      output logic [31:0] rdat, output logic rvld);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_op1 = op1;
    cmd_crn = crn;
    cmd_crm = crm;
    cmd_op2 = op2;
    cmd_wdata = wd;
    @(negedge clk);
    rdat = rd_data;
    rvld = rd_valid;
  endtask
  // idle fields flip so a stale field never looks like a live command
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_read = ~cmd_read;
    cmd_op1 = ~cmd_op1;
    cmd_crn = ~cmd_crn;
    cmd_crm = ~cmd_crm;
    cmd_op2 = ~cmd_op2;
    cmd_wdata = ~cmd_wdata;
    @(negedge clk);
  endtask
endmodule // cta_core_model
`default_nettype wire

// [tb/cache_test_access_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cache_test_access_tb;
  import cta_pkg::*;
  logic clk, srst, prod_test, cmd_valid, cmd_read, rd_valid, rvld;
  logic [2:0] cmd_op1, cmd_op2;
  logic [3:0] cmd_crn, cmd_crm;
  logic [31:0] cmd_wdata, rd_data, itd, dtd, rdat;
  logic [5:0] sn_i, sn_d, exp_i, exp_d;
  int err_total, num_checks;

  cta_top dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_op1(cmd_op1), .cmd_crn(cmd_crn), .cmd_crm(cmd_crm), .cmd_op2(cmd_op2),
    .cmd_wdata(cmd_wdata), .prod_test(prod_test), .rd_data(rd_data), .rd_valid(rd_valid),
    .icache_test_data(itd), .dcache_test_data(dtd), .victim_snapshot_reg_i(sn_i),
    .victim_snapshot_reg_d(sn_d));
  cta_core_model core (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_op1(cmd_op1), .cmd_crn(cmd_crn),
    .cmd_crm(cmd_crm), .cmd_op2(cmd_op2), .cmd_wdata(cmd_wdata));

  always #10 clk = ~clk;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic test(logic [3:0] crm, logic [2:0] op2, logic [31:0] wd);
    core.xfer(1'b0, CTA_OP1_TEST, CTA_CRN_TEST, crm, op2, wd, rdat, rvld);
  endtask
  task automatic tdr(logic [3:0] crm, logic [31:0] v);
    core.xfer(1'b0, CTA_OP1_TDR, CTA_CRN_TEST, crm, CTA_OP2_TDR, v, rdat, rvld);
  endtask
  task automatic rd(logic [3:0] crm);
    core.xfer(1'b1, CTA_OP1_TDR, CTA_CRN_TEST, crm, CTA_OP2_TDR, 32'h0, rdat, rvld);
    check("rd_valid", {31'h0, rvld}, 32'h1);
  endtask
  task automatic vict(logic only, logic ic, logic [5:0] idx, logic [2:0] seg);
    core.xfer(1'b0, CTA_OP1_STD, CTA_CRN_VICT, only ? CTA_CRM_VONLY : CTA_CRM_VBASE,
      ic ? CTA_OP2_VI : CTA_OP2_VD, {idx, 18'h0, seg, 5'h0}, rdat, rvld);
  endtask
  function automatic logic [31:0] cam_op(logic [23:0] tag, logic [2:0] seg, logic [3:0] fl);
    return {tag, seg, fl, 1'b0};
  endfunction
  function automatic logic [31:0] addr(logic [2:0] seg, logic [2:0] word);
    return {24'h0, seg, word, 2'h0};
  endfunction

  task automatic t_reset();
    check("itd", itd, 32'h0);
    check("dtd", dtd, 32'h0);
    check("snap", {20'h0, sn_i, sn_d}, 32'h0);
    check("rd_valid", {31'h0, rd_valid}, 32'h0);
  endtask
  task automatic t_tdr();
    tdr(CTA_CRM_TDR_I, 32'ha5a50001);
    check("rd_valid", {31'h0, rvld}, 32'h0);
    tdr(CTA_CRM_TDR_D, 32'h5a5a0002);
    rd(CTA_CRM_TDR_I);
    check("rd_i", rdat, 32'ha5a50001);
    rd(CTA_CRM_TDR_D);
    check("rd_d", rdat, 32'h5a5a0002);
    tdr(4'h4, 32'hffffffff);
    tdr(CTA_CRM_TDR_B, 32'h13572468);
    check("itd", itd, 32'h13572468);
    check("dtd", dtd, 32'h13572468);
    core.idle();
  endtask
  // each cache selector, instruction, data and both
  task automatic t_codes();
    logic [31:0] c;
    for (int k = 0; k < 3; k++) begin
      c = cam_op(24'h5a0000 + 24'(k), 3'(k + 1), {1'b1, 1'(k), ~1'(k), 1'b1});
      tdr(CTA_CRM_TDR_I, 32'h11110000 + 32'(k));
      tdr(CTA_CRM_TDR_D, 32'h22220000 + 32'(k));
      for (int j = 0; j < 4; j++) begin
        if (j == 2) tdr(CTA_CRM_TDR_B, 32'h0);
        vict(1'b0, 1'b1, 6'(8 * k + 3), 3'h0);
        vict(1'b0, 1'b0, 6'(8 * k + 3), 3'h0);
        case (j)
          0: test(CTA_CRM_RAM_I + 4'(k), CTA_OP2_WR, addr(3'(k + 1), 3'(k + 2)));
          1: test(CTA_CRM_CAM_I + 4'(k), CTA_OP2_WR, c);
          2: test(CTA_CRM_RAM_I + 4'(k), CTA_OP2_RD, addr(3'(k + 1), 3'(k + 2)));
          default: test(CTA_CRM_CAM_I + 4'(k), CTA_OP2_RD, {24'h0, 3'(k + 1), 5'h0});
        endcase
      end
      check("itd", itd, k == 1 ? 32'h0 : c);
      check("dtd", dtd, k == 0 ? 32'h0 : c);
      if (k != 1) exp_i = 6'(8 * k + 3);
      if (k != 0) exp_d = 6'(8 * k + 3);
      check("snap_i", {26'h0, sn_i}, {26'h0, exp_i});
      check("snap_d", {26'h0, sn_d}, {26'h0, exp_d});
      tdr(CTA_CRM_TDR_B, 32'h0);
      vict(1'b0, 1'b1, 6'(8 * k + 3), 3'h0);
      vict(1'b0, 1'b0, 6'(8 * k + 3), 3'h0);
      test(CTA_CRM_RAM_I + 4'(k), CTA_OP2_RD, addr(3'(k + 1), 3'(k + 2)));
      check("ram_i", itd, k == 1 ? 32'h0 : 32'h11110000 + 32'(k));
      check("ram_d", dtd, k == 0 ? 32'h0 : 32'h22220000 + 32'(k));
    end
    core.idle();
  endtask
  task automatic t_ptr();
    vict(1'b0, 1'b0, 6'd40, 3'h0);
    test(CTA_CRM_RAM_D, CTA_OP2_RD, addr(3'h2, 3'h0));
    test(CTA_CRM_RAM_D, CTA_OP2_RD, addr(3'h2, 3'h1));
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h2, 5'h0});
    check("snap_d", {26'h0, sn_d}, 32'd42);
    vict(1'b1, 1'b0, 6'd50, 3'h2);
    vict(1'b1, 1'b0, 6'd7, 3'h4);
    test(CTA_CRM_RAM_D, CTA_OP2_RD, addr(3'h2, 3'h0));
    test(CTA_CRM_RAM_D, CTA_OP2_WR, addr(3'h2, 3'h1));
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h2, 5'h0});
    check("snap_d", {26'h0, sn_d}, 32'd50);
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h4, 5'h0});
    check("snap_d", {26'h0, sn_d}, 32'd7);
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h2, 5'h0});
    check("snap_d", {26'h0, sn_d}, 32'd51);
    prod_test = 1'b1;
    vict(1'b0, 1'b0, 6'd60, 3'h0);
    test(CTA_CRM_RAM_D, CTA_OP2_RD, addr(3'h2, 3'h0));
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h2, 5'h0});
    test(CTA_CRM_CAM_D, CTA_OP2_RD, {24'h0, 3'h2, 5'h0});
    check("snap_d", {26'h0, sn_d}, 32'd61);
    prod_test = 1'b0;
    core.idle();
  endtask
  task automatic t_match();
    vict(1'b0, 1'b0, 6'd0, 3'h0);
    repeat (64) test(CTA_CRM_CAM_D, CTA_OP2_WR, cam_op(24'h0, 3'h3, 4'h0));
    vict(1'b1, 1'b0, 6'd10, 3'h3);
    tdr(CTA_CRM_TDR_D, 32'hcafe0005);
    test(CTA_CRM_RAM_D, CTA_OP2_WR, addr(3'h3, 3'h5));
    test(CTA_CRM_CAM_D, CTA_OP2_WR, cam_op(24'hbeef01, 3'h3, 4'h8));
    tdr(CTA_CRM_TDR_D, 32'h0);
    test(CTA_CRM_CAM_D, CTA_OP2_MATCH, {24'hbeef01, 3'h3, 3'h5, 2'h3});
    check("match", dtd, 32'hcafe0005);
    rd(4'h0);
    check("hit", rdat, 32'h2);
    test(CTA_CRM_CAM_D, CTA_OP2_MATCH, {24'hbeef00, 3'h3, 3'h5, 2'h0});
    check("miss", dtd, 32'h0);
    rd(4'h0);
    check("hit", rdat, 32'h0);
    core.idle();
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    prod_test = 1'b0;
    err_total = 0;
    num_checks = 0;
    exp_i = 6'h0;
    exp_d = 6'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset();
    t_tdr();
    t_codes();
    t_ptr();
    t_match();
    end_sim();
  end
  // whole run needs about 160 cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule // cache_test_access_tb
`default_nettype wire
